/* hw/lsru_pkg.sv */
// Purpose: shared types and constants of the load/store reorder unit
// Assumes: 32-bit words, 32 general registers, 4-Kbyte pages
// Notes: byte 0 of a memory word is its most significant byte
package lsru_pkg;

    // ----------------------------------------------------------------
    // widths and counts
    // ----------------------------------------------------------------
    localparam int unsigned word_w = 32;
    localparam int unsigned reg_w = 5;
    localparam int unsigned fifo_depth = 8;
    localparam logic [5:0] reg_count = 6'h20;
    localparam logic [4:0] register_zero = 5'h00;
    localparam int unsigned page_lsb = 12;
    localparam logic [1:0] word_lane_mask = 2'h3;
    localparam logic [31:0] zero_word = 32'h0000_0000;
    localparam logic [15:0] zero_half = 16'h0000;
    localparam logic [31:0] word_step = 32'h0000_0004;

    // ----------------------------------------------------------------
    // operations
    // ----------------------------------------------------------------
    typedef enum logic [3:0] {
        op_load_half_swapped = 4'h0,
        op_load_word_swapped = 4'h1,
        op_store_half_swapped = 4'h2,
        op_store_word_swapped = 4'h3,
        op_load_many_words = 4'h4,
        op_store_many_words = 4'h5,
        op_load_string_imm = 4'h6,
        op_load_string_idx = 4'h7,
        op_store_string_imm = 4'h8,
        op_store_string_idx = 4'h9,
        op_fp_load = 4'ha,
        op_fp_store = 4'hb
    } op_t;

    typedef enum logic [1:0] {
        st_idle = 2'h0,
        st_issue = 2'h1,
        st_wait = 2'h2,
        st_done = 2'h3
    } state_t;

    typedef enum logic [1:0] {
        fault_none = 2'h0,
        fault_storage = 2'h1,
        fault_alignment = 2'h2
    } fault_t;

    // request from the pipeline
    typedef struct packed {
        op_t op;
        logic [4:0] base_reg_field;
        logic [4:0] index_reg_field;
        logic [4:0] source_reg_field;
        logic [6:0] byte_count_immediate;
        logic [15:0] displacement;
        logic [31:0] base_value;
        logic [31:0] index_value;
        logic [31:0] source_value;
        logic little_endian;
        logic direct_store_seg;
    } request_t;

    // one word access to memory
    typedef struct packed {
        logic write;
        logic [31:0] addr;
        logic [3:0] byte_en;
        logic [31:0] data;
    } mem_req_t;

    // one register write back to the pipeline
    typedef struct packed {
        logic [4:0] dest;
        logic [31:0] data;
    } reg_wb_t;

endpackage

/* hw/lsru_fifo.sv */
// Purpose: small valid/ready FIFO for register write-back words
// Assumes: depth is a power of two
// Notes: full and empty are exact; one read and one write per cycle
`timescale 1ns/1ns
module lsru_fifo #(
    parameter int unsigned width = 37,
    parameter int unsigned depth = 8
) (
    // clock and reset
    input wire logic clock,
    input wire logic rstn,
    // fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [width-1:0] in_data,
    // drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [width-1:0] out_data
);
    localparam int unsigned aw = $clog2(depth);

    typedef struct packed {
        logic [aw:0] wr;
        logic [aw:0] rd;
    } fifo_state_t;

    logic [width-1:0] mem [depth];
    fifo_state_t s_r;
    fifo_state_t s_nxt;
    logic push;
    logic pop;

    // ----------------------------------------------------------------
    // pointers
    // ----------------------------------------------------------------
    assign out_valid = s_r.wr != s_r.rd;
    assign in_ready = s_r.wr != {~s_r.rd[aw], s_r.rd[aw-1:0]};
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign out_data = mem[s_r.rd[aw-1:0]];

    // next pointer values
    always_comb begin
        s_nxt = s_r;
        if (push) begin
            s_nxt.wr = s_r.wr + 1'b1;
        end
        if (pop) begin
            s_nxt.rd = s_r.rd + 1'b1;
        end
    end

    // state and storage
    always_ff @(posedge clock) begin
        if (!rstn) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
        if (push) begin
            mem[s_r.wr[aw-1:0]] <= in_data;
        end
    end
endmodule

/* hw/lsru.sv */
// Purpose: byte-reversed, multiple, string and fp-address load/store unit
// Assumes: memory answers each word access with mem_ack, data in mem_rdata
// Notes: string moves go word by word with byte enables, any alignment
`timescale 1ns/1ns

module lsru (
    // clock and reset
    input wire logic clock,
    input wire logic rstn,
    // request from the pipeline
    input wire logic req_valid,
    output logic req_ready,
    input wire lsru_pkg::request_t req,
    // memory port
    output logic mem_valid,
    output lsru_pkg::mem_req_t mem_req,
    input wire logic mem_ack,
    input wire logic [31:0] mem_rdata,
    input wire logic mem_fault,
    // register write back
    output logic wb_valid,
    input wire logic wb_ready,
    output lsru_pkg::reg_wb_t wb,
    // completion
    output logic done_valid,
    output lsru_pkg::fault_t done_fault,
    output logic [31:0] effective_address
);
    typedef struct packed {
        lsru_pkg::state_t state;
        lsru_pkg::request_t rq;
        logic [31:0] addr;
        logic [6:0] left;
        logic [4:0] reg_ptr;
        logic [1:0] lane;
        logic [31:0] acc;
        logic [31:0] ea;
        logic mem_valid;
        lsru_pkg::mem_req_t mreq;
        logic push;
        lsru_pkg::reg_wb_t push_data;
        logic done;
        lsru_pkg::fault_t fault;
    } core_state_t;

    core_state_t s_r;
    core_state_t s_nxt;
    logic fifo_ready;
    logic [31:0] base_or_zero;
    logic [31:0] new_ea;
    logic [6:0] total;
    logic [2:0] chunk;
    logic [3:0] ben;
    logic [31:0] sdata;
    logic [31:0] rmerge;
    logic [4:0] reg_next;

    // ----------------------------------------------------------------
    // address generation
    // ----------------------------------------------------------------
    // base register or zero
    assign base_or_zero = (req.base_reg_field == lsru_pkg::register_zero)
        ? lsru_pkg::zero_word : req.base_value;

    // effective address per operation
    always_comb begin
        case (req.op)
            lsru_pkg::op_load_string_imm,
            lsru_pkg::op_store_string_imm: begin
                new_ea = base_or_zero;
            end
            lsru_pkg::op_load_many_words, lsru_pkg::op_store_many_words,
            lsru_pkg::op_fp_load, lsru_pkg::op_fp_store: begin
                new_ea = base_or_zero
                    + {{16{req.displacement[15]}}, req.displacement};
            end
            default: begin
                new_ea = base_or_zero + req.index_value;
            end
        endcase
    end

    // byte total per operation
    always_comb begin
        case (req.op)
            lsru_pkg::op_load_many_words, lsru_pkg::op_store_many_words: begin
                total = 7'({(lsru_pkg::reg_count
                    - {1'b0, req.source_reg_field}), 2'b00});
            end
            lsru_pkg::op_load_string_imm,
            lsru_pkg::op_store_string_imm: begin
                total = req.byte_count_immediate;
            end
            lsru_pkg::op_load_string_idx,
            lsru_pkg::op_store_string_idx: begin
                total = req.index_value[6:0];
            end
            default: begin
                total = 7'h00;
            end
        endcase
    end

    // ----------------------------------------------------------------
    // word slicing for multiple and string moves
    // ----------------------------------------------------------------
    // bytes in this memory word, limited by lane, data lane and count
    always_comb begin
        logic [2:0] room_m;
        logic [2:0] room_r;
        room_m = 3'h4 - {1'b0, s_r.addr[1:0]};
        room_r = 3'h4 - {1'b0, s_r.lane};
        chunk = (room_m < room_r) ? room_m : room_r;
        if ({4'h0, chunk} > s_r.left) begin
            chunk = s_r.left[2:0];
        end
        ben = 4'h0;
        sdata = lsru_pkg::zero_word;
        for (int i = 0; i < 4; i++) begin
            if (i >= s_r.addr[1:0] && i < s_r.addr[1:0] + chunk) begin
                ben[3-i] = 1'b1;
                sdata[8*(3-i) +: 8] =
                    s_r.acc[8*(3-(i-s_r.addr[1:0]-0-0+s_r.lane)) +: 8];
            end
        end
        rmerge = s_r.acc;
        for (int i = 0; i < 4; i++) begin
            if (i >= s_r.lane && i < s_r.lane + chunk) begin
                rmerge[8*(3-i) +: 8] =
                    mem_rdata[8*(3-(i-s_r.lane+s_r.addr[1:0])) +: 8];
            end
        end
        reg_next = s_r.reg_ptr + 5'h01;
    end

    // ----------------------------------------------------------------
    // sequencer
    // ----------------------------------------------------------------
    always_comb begin
        logic multi;
        logic is_load;
        logic [2:0] lane_sum;
        s_nxt = s_r;
        s_nxt.push = 1'b0;
        s_nxt.done = 1'b0;
        multi = 1'b0;
        is_load = 1'b0;
        lane_sum = {1'b0, s_r.lane} + chunk;
        case (s_r.state)
            lsru_pkg::st_idle: begin
                if (req_valid) begin
                    s_nxt.rq = req;
                    s_nxt.ea = new_ea;
                    s_nxt.addr = new_ea;
                    s_nxt.left = total;
                    s_nxt.reg_ptr = req.source_reg_field;
                    s_nxt.lane = 2'h0;
                    s_nxt.acc = (req.op == lsru_pkg::op_store_many_words
                        || req.op == lsru_pkg::op_store_string_imm
                        || req.op == lsru_pkg::op_store_string_idx)
                        ? req.source_value : lsru_pkg::zero_word;
                    s_nxt.fault = lsru_pkg::fault_none;
                    s_nxt.state = lsru_pkg::st_issue;
                    multi = req.op >= lsru_pkg::op_load_many_words
                        && req.op <= lsru_pkg::op_store_string_idx;
                    if (multi && req.little_endian) begin
                        s_nxt.fault = lsru_pkg::fault_alignment;
                        s_nxt.state = lsru_pkg::st_done;
                    end
                    if ((req.op == lsru_pkg::op_fp_load
                        || req.op == lsru_pkg::op_fp_store)
                        && req.direct_store_seg) begin
                        s_nxt.fault = lsru_pkg::fault_alignment;
                        s_nxt.state = lsru_pkg::st_done;
                    end
                    if (multi && total == 7'h00) begin
                        s_nxt.state = lsru_pkg::st_done;
                    end
                end
            end
            lsru_pkg::st_issue: begin
                // hold off while a push is in flight or the buffer is full
                s_nxt.mem_valid = fifo_ready && !s_r.push;
                s_nxt.mreq.addr = {s_r.addr[31:2], 2'b00};
                s_nxt.mreq.write = s_r.rq.op == lsru_pkg::op_store_many_words
                    || s_r.rq.op == lsru_pkg::op_store_string_imm
                    || s_r.rq.op == lsru_pkg::op_store_string_idx;
                s_nxt.mreq.byte_en = ben;
                s_nxt.mreq.data = sdata;
                case (s_r.rq.op)
                    lsru_pkg::op_store_half_swapped: begin
                        s_nxt.mreq.byte_en = s_r.addr[1] ? 4'h3 : 4'hc;
                        s_nxt.mreq.data = {2{s_r.rq.source_value[7:0],
                            s_r.rq.source_value[15:8]}};
                        s_nxt.mreq.write = 1'b1;
                    end
                    lsru_pkg::op_store_word_swapped: begin
                        s_nxt.mreq.byte_en = 4'hf;
                        s_nxt.mreq.data = {<<8{s_r.rq.source_value}};
                        s_nxt.mreq.write = 1'b1;
                    end
                    lsru_pkg::op_load_half_swapped,
                    lsru_pkg::op_load_word_swapped,
                    lsru_pkg::op_fp_load: begin
                        s_nxt.mreq.byte_en = 4'hf;
                        s_nxt.mreq.write = 1'b0;
                    end
                    lsru_pkg::op_fp_store: begin
                        s_nxt.mreq.byte_en = 4'hf;
                        s_nxt.mreq.data = s_r.rq.source_value;
                        s_nxt.mreq.write = 1'b1;
                    end
                    default: begin
                    end
                endcase
                s_nxt.state = s_nxt.mem_valid ? lsru_pkg::st_wait
                    : lsru_pkg::st_issue;
            end
            lsru_pkg::st_wait: begin
                is_load = !s_r.mreq.write;
                if (mem_ack) begin
                    s_nxt.mem_valid = 1'b0;
                    s_nxt.state = lsru_pkg::st_done;
                    if (mem_fault) begin
                        s_nxt.fault = lsru_pkg::fault_storage;
                    end else if (s_r.rq.op == lsru_pkg::op_load_half_swapped)
                    begin
                        s_nxt.push = 1'b1;
                        s_nxt.push_data.dest = s_r.rq.source_reg_field;
                        s_nxt.push_data.data = s_r.addr[1]
                            ? {lsru_pkg::zero_half, mem_rdata[7:0],
                               mem_rdata[15:8]}
                            : {lsru_pkg::zero_half, mem_rdata[23:16],
                               mem_rdata[31:24]};
                    end else if (s_r.rq.op == lsru_pkg::op_load_word_swapped)
                    begin
                        s_nxt.push = 1'b1;
                        s_nxt.push_data.dest = s_r.rq.source_reg_field;
                        s_nxt.push_data.data = {<<8{mem_rdata}};
                    end else if (s_r.rq.op >= lsru_pkg::op_load_many_words
                        && s_r.rq.op <= lsru_pkg::op_store_string_idx) begin
                        s_nxt.addr = s_r.addr + {29'h0, chunk};
                        s_nxt.left = s_r.left - {4'h0, chunk};
                        s_nxt.lane = lane_sum[1:0];
                        s_nxt.acc = is_load ? rmerge : s_r.acc;
                        if (is_load && (lane_sum[2] || s_r.left == {4'h0,
                            chunk})) begin
                            s_nxt.push = 1'b1;
                            s_nxt.push_data.dest = s_r.reg_ptr;
                            s_nxt.push_data.data = rmerge;
                            s_nxt.acc = lsru_pkg::zero_word;
                        end
                        if (lane_sum[2]) begin
                            s_nxt.reg_ptr = reg_next; // wraps to zero
                            if (!is_load) begin
                                s_nxt.acc = s_r.rq.source_value; // see note
                            end
                        end
                        if (s_r.left != {4'h0, chunk}) begin
                            s_nxt.state = lsru_pkg::st_issue;
                        end
                    end
                end
            end
            lsru_pkg::st_done: begin
                s_nxt.done = 1'b1;
                s_nxt.state = lsru_pkg::st_idle;
            end
            default: begin
                s_nxt.state = lsru_pkg::st_idle;
            end
        endcase
    end

    // state register
    always_ff @(posedge clock) begin
        if (!rstn) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    // ----------------------------------------------------------------
    // write-back buffer
    // ----------------------------------------------------------------
    lsru_fifo #(.width($bits(lsru_pkg::reg_wb_t)), .depth(lsru_pkg::fifo_depth))
    u_fifo (
        .clock(clock),
        .rstn(rstn),
        .in_valid(s_r.push),
        .in_ready(fifo_ready),
        .in_data(s_r.push_data),
        .out_valid(wb_valid),
        .out_ready(wb_ready),
        .out_data(wb)
    );

    assign req_ready = s_r.state == lsru_pkg::st_idle;
    assign mem_valid = s_r.mem_valid;
    assign mem_req = s_r.mreq;
    assign done_valid = s_r.done;
    assign done_fault = s_r.fault;
    assign effective_address = s_r.ea;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    // alignment refusal: taken, then two cycles later a faulted completion
    sequence align_done_s;
        ##1 done_valid && done_fault == lsru_pkg::fault_alignment;
    endsequence
    swap_word_a: assert property (@(posedge clock) disable iff (!rstn)
        s_r.state == lsru_pkg::st_wait && mem_ack && !mem_fault
        && s_r.rq.op == lsru_pkg::op_load_word_swapped
        |=> s_r.push_data.data == {<<8{$past(mem_rdata)}})
        else $error("swapped word load wrong");
    fp_fault_a: assert property (@(posedge clock) disable iff (!rstn)
        req_ready && req_valid && req.op == lsru_pkg::op_fp_load
        && req.direct_store_seg |=> align_done_s)
        else $error("direct-store fp access not faulted");
    le_multi_a: assert property (@(posedge clock) disable iff (!rstn)
        req_ready && req_valid && req.op == lsru_pkg::op_load_many_words
        && req.little_endian |=> align_done_s)
        else $error("little-endian multiple not faulted");
    half_zero_a: assert property (@(posedge clock) disable iff (!rstn)
        s_r.push && s_r.rq.op == lsru_pkg::op_load_half_swapped
        |-> s_r.push_data.data[31:16] == lsru_pkg::zero_half)
        else $error("swapped half load upper bits not clear");
    zero_base_a: assert property (@(posedge clock) disable iff (!rstn)
        req_ready && req_valid && req.op == lsru_pkg::op_fp_store
        && req.base_reg_field == lsru_pkg::register_zero
        |=> s_r.ea == {{16{$past(req.displacement[15])}},
        $past(req.displacement)})
        else $error("register zero base not taken as zero");
    mem_hold_a: assert property (@(posedge clock) disable iff (!rstn)
        mem_valid && !mem_ack |=> mem_valid && $stable(mem_req))
        else $error("memory request dropped before answer");
endmodule

/* dv/mem_model.sv */
// Purpose: behavioural memory behind the load/store unit
// Assumes: byte 0 of a word sits in bits 31:24, byte_en[i] covers byte 3-i
// Notes: rdata shows the inverse of the last value while not answering
`timescale 1ns/1ns
module mem_model (
    // clock
    input wire logic clock,
    // memory port
    input wire logic mem_valid,
    input wire lsru_pkg::mem_req_t mem_req,
    output logic mem_ack,
    output logic [31:0] mem_rdata,
    output logic mem_fault,
    // test controls
    input wire logic [3:0] delay,
    input wire logic fault_en
);
    logic [31:0] words [0:63];
    logic [3:0] wait_r;
    logic gap_r;
    logic [31:0] last_r;
    initial begin
        mem_ack = 1'b0;
        mem_fault = 1'b0;
        mem_rdata = 32'h0000_0000;
        wait_r = 4'h0;
        gap_r = 1'b0;
        last_r = 32'h0000_0000;
    end
    // answer a held request after delay cycles, then rest one cycle
    always @(posedge clock) begin
        mem_ack <= 1'b0;
        mem_fault <= 1'b0;
        mem_rdata <= ~last_r;
        if (gap_r || !mem_valid) begin
            gap_r <= 1'b0;
            wait_r <= 4'h0;
        end else if (wait_r < delay) begin
            wait_r <= wait_r + 4'h1;
        end else begin
            mem_ack <= 1'b1;
            gap_r <= 1'b1;
            if (fault_en && mem_req.addr[12]) begin
                mem_fault <= 1'b1; // second page fails translation
            end else if (mem_req.write) begin
                for (int i = 0; i < 4; i++) begin
                    if (mem_req.byte_en[i]) begin
                        words[mem_req.addr[7:2]][8*i +: 8] <=
                            mem_req.data[8*i +: 8];
                    end
                end
            end else begin
                mem_rdata <= words[mem_req.addr[7:2]];
                last_r <= words[mem_req.addr[7:2]];
            end
        end
    end
endmodule

/* dv/tb_top.sv */
// Purpose: self-checking bench of the load/store reorder unit
// Assumes: loads write back to source_reg_field upward
// Notes: expected write-backs and completions queue up for the monitor
`timescale 1ns/1ns
module tb_top;
    typedef struct packed {
        lsru_pkg::fault_t f;
        logic [31:0] ea;
        logic ck;
    } exp_done_t;
    logic clock, rstn, req_valid, req_ready, mem_valid, mem_ack, mem_fault;
    logic wb_valid, wb_ready, done_valid, fault_en, stall;
    logic [31:0] mem_rdata, effective_address;
    logic [3:0] delay;
    lsru_pkg::request_t req;
    lsru_pkg::mem_req_t mem_req;
    lsru_pkg::reg_wb_t wb;
    lsru_pkg::fault_t done_fault;
    lsru_pkg::reg_wb_t exp_wb[$];
    exp_done_t exp_done[$];
    int miscompares, n_tests, n_done, cycles, seed;
    logic [31:0] v, a;

    lsru dut (.clock(clock), .rstn(rstn), .req_valid(req_valid),
        .req_ready(req_ready), .req(req), .mem_valid(mem_valid),
        .mem_req(mem_req), .mem_ack(mem_ack), .mem_rdata(mem_rdata),
        .mem_fault(mem_fault), .wb_valid(wb_valid), .wb_ready(wb_ready),
        .wb(wb), .done_valid(done_valid), .done_fault(done_fault),
        .effective_address(effective_address));
    mem_model mm (.clock(clock), .mem_valid(mem_valid), .mem_req(mem_req),
        .mem_ack(mem_ack), .mem_rdata(mem_rdata), .mem_fault(mem_fault),
        .delay(delay), .fault_en(fault_en));

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic check(string what, logic [31:0] e, logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            miscompares++;
            $display("FAIL %s expected %h seen %h", what, e, g);
        end
    endtask
    function automatic logic [7:0] mb(logic [31:0] ad);
        return mm.words[ad[7:2]][8*(3-ad[1:0]) +: 8];
    endfunction
    function automatic lsru_pkg::request_t mk(lsru_pkg::op_t op,
        logic [4:0] bf, logic [4:0] sf, logic [31:0] bv, logic [31:0] iv,
        logic [31:0] sv, logic [15:0] d);
        lsru_pkg::request_t r;
        r = '0;
        r.op = op;
        r.base_reg_field = bf;
        r.index_reg_field = 5'h07;
        r.source_reg_field = sf;
        r.base_value = bv;
        r.index_value = iv;
        r.source_value = sv;
        r.displacement = d;
        return r;
    endfunction
    task automatic run(string name, lsru_pkg::request_t r,
        lsru_pkg::fault_t f, logic [31:0] ea, logic ck);
        int seen;
        int k;
        exp_done.push_back('{f, ea, ck});
        seen = n_done;
        delay = 4'($random(seed) & 3);
        @(negedge clock);
        req_valid = 1'b1;
        req = r;
        while (!req_ready) @(negedge clock);
        @(negedge clock);
        req_valid = 1'b0;
        for (k = 0; k < 3000 && n_done == seen; k++) @(negedge clock);
        if (n_done == seen) begin
            miscompares++;
            $display("FAIL done %s expected 1 seen 0", name);
        end
        $display("test %s ended", name);
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // clock, timeout, write-back stall and monitor
    // ------------------------------------------------------------
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    always @(negedge clock) begin
        cycles++;
        wb_ready <= stall ? 1'b0 : 1'($random(seed));
        if (cycles == 20000) begin
            miscompares++;
            final_report();
        end
    end
    always @(posedge clock) begin
        if (rstn && wb_valid && wb_ready) begin
            check("wb", {27'h0, exp_wb[0].dest}, {27'h0, wb.dest});
            check("wb data", exp_wb[0].data, wb.data);
            void'(exp_wb.pop_front());
        end
        if (rstn && done_valid) begin
            check("fault", 32'(exp_done[0].f), 32'(done_fault));
            if (exp_done[0].ck) begin
                check("ea", exp_done[0].ea, effective_address);
            end
            void'(exp_done.pop_front());
            n_done++;
        end
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        seed = 71;
        rstn = 1'b0;
        req_valid = 1'b0;
        req = '0;
        fault_en = 1'b0;
        stall = 1'b0;
        delay = 4'h0;
        wb_ready = 1'b1;
        for (int i = 0; i < 64; i++) mm.words[i] = $random(seed);
        repeat (3) @(posedge clock);
        @(negedge clock);
        rstn = 1'b1;
        // half and word swapped loads, base field zero adds zero
        a = 32'h40 + (32'($random(seed)) & 32'h3e);
        exp_wb.push_back('{5'h03, {16'h0, mb(a + 1), mb(a)}});
        run("lhs", mk(lsru_pkg::op_load_half_swapped, 5'h02, 5'h03,
            32'h40, a - 32'h40, 0, 0), lsru_pkg::fault_none, a, 1);
        v = mm.words[5'h09];
        exp_wb.push_back('{5'h04, {v[7:0], v[15:8], v[23:16], v[31:24]}});
        run("lws", mk(lsru_pkg::op_load_word_swapped, 5'h00, 5'h04,
            32'hdead_beef, 32'h24, 0, 0), lsru_pkg::fault_none,
            32'h24, 1);
        // swapped stores
        v = $random(seed);
        run("shs", mk(lsru_pkg::op_store_half_swapped, 5'h01, 5'h05,
            32'h50, 32'h2, v, 0), lsru_pkg::fault_none, 32'h52, 1);
        check("half", {v[7:0], v[15:8]}, {mb(32'h52), mb(32'h53)});
        run("sws", mk(lsru_pkg::op_store_word_swapped, 5'h01, 5'h05,
            32'h50, 32'h8, v, 0), lsru_pkg::fault_none, 32'h58, 1);
        check("word", {v[7:0], v[15:8], v[23:16], v[31:24]},
            mm.words[5'h16]);
        // fp address forms and direct-store refusal
        run("fpneg", mk(lsru_pkg::op_fp_store, 5'h06, 5'h01, 32'h80, 0, v,
            16'hfff0), lsru_pkg::fault_none, 32'h70, 1);
        run("fpr0", mk(lsru_pkg::op_fp_store, 5'h00, 5'h01, 32'h80, 0, v,
            16'h0020), lsru_pkg::fault_none, 32'h20, 1);
        req = mk(lsru_pkg::op_fp_load, 5'h06, 5'h01, 32'h80, 0, 0, 0);
        req.direct_store_seg = 1'b1;
        run("fpds", req, lsru_pkg::fault_alignment, 0, 0);
        // twelve words into a stalled write-back buffer
        stall = 1'b1;
        for (int i = 0; i < 12; i++) begin
            exp_wb.push_back('{5'(20 + i), mm.words[32 + i]});
        end
        fork
            run("lmw", mk(lsru_pkg::op_load_many_words, 5'h01, 5'd20,
                32'h78, 0, 0, 16'h0008), lsru_pkg::fault_none, 32'h80, 1);
            begin
                repeat (60) @(negedge clock);
                stall = 1'b0;
            end
        join
        run("stmw", mk(lsru_pkg::op_store_many_words, 5'h01, 5'd30,
            32'ha0, 0, v, 0), lsru_pkg::fault_none, 32'ha0, 1);
        check("stmw", v, mm.words[41]);
        // misaligned string load, immediate form
        exp_wb.push_back('{5'd8, {mb(32'h41), mb(32'h42), mb(32'h43),
            mb(32'h44)}});
        exp_wb.push_back('{5'd9, {mb(32'h45), mb(32'h46), mb(32'h47),
            mb(32'h48)}});
        req = mk(lsru_pkg::op_load_string_imm, 5'h02, 5'd8, 32'h41, 0, 0, 0);
        req.byte_count_immediate = 7'h08;
        run("lsi", req, lsru_pkg::fault_none, 32'h41, 1);
        // little-endian refusals and a second-page fault
        req.little_endian = 1'b1;
        run("lsle", req, lsru_pkg::fault_alignment, 0, 0);
        req.op = lsru_pkg::op_load_many_words;
        req.source_reg_field = 5'd28;
        run("lmle", req, lsru_pkg::fault_alignment, 0, 0);
        fault_en = 1'b1;
        exp_wb.push_back('{5'd24, mm.words[62]});
        exp_wb.push_back('{5'd25, mm.words[63]});
        // base register 1 lies below the loaded range
        run("lmpg", mk(lsru_pkg::op_load_many_words, 5'h01, 5'd24,
            32'hff8, 0, 0, 0), lsru_pkg::fault_storage, 0, 0);
        repeat (10) @(negedge clock);
        check("wb left", 0, exp_wb.size());
        final_report();
    end
endmodule
